// ---- verilog/user_pattern_ram_icon_pattern_map.sv ----
// User pattern RAM, glyph row fetch with cursor merge, and icon RAM
`timescale 1ns/1ns
`include "user_pattern_ram_icon_consts.svh"
module user_pattern_ram_icon_pattern_map (
  // Clock and reset
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       ARST_N_I,
  // Option pins
  input  wire logic [`STRAP_W-1:0]        ROM_OPTION_STRAPS_I,
  input  wire logic                       SEGMENT_ORDER_SELECT_I,
  // RAM access from the instruction decoder
  input  wire logic                       RAM_WR_I,
  input  wire logic                       RAM_RD_I,
  input  wire user_pattern_ram_icon_pkg::ram_sel_t   RAM_SEL_I,
  input  wire logic [`TEXT_ADDR_W-1:0]    ADDRESS_COUNTER_I,
  input  wire logic [7:0]                 WDATA_I,
  output logic [7:0]                      RDATA_O,
  output logic                            RDATA_VALID_O,
  // Display row fetch
  input  wire logic                       FETCH_I,
  input  wire logic [7:0]                 CHAR_CODE_I,
  input  wire logic [2:0]                 ROW_I,
  input  wire logic [`TEXT_ADDR_W-1:0]    TEXT_ADDR_I,
  input  wire logic                       CURSOR_ON_I,
  input  wire logic [`DOTS_W-1:0]         ROM_ROW_I,
  output logic [`DOTS_W-1:0]              ROW_DOTS_O,
  output logic                            ROW_VALID_O,
  output logic                            USER_GLYPH_O,
  // Icon segments, bit k is segment k+1
  output user_pattern_ram_icon_pkg::seg_vec_t        ICON_SEG_O
);

  logic                      rst_meta;
  logic                      rst_n;
  logic [`STRAP_W-1:0]       strap_meta;
  logic [`STRAP_W-1:0]       strap_sync;
  logic                      order_meta;
  logic                      order_sync;
  logic [3:0]                user_pats;
  // Pattern RAM: glyph select in address bits 5..3, row in bits 2..0
  logic [7:0]                pattern_ram [`PAT_DEPTH];
  logic [`ICON_BITS-1:0]     icon_ram [`ICON_DEPTH];
  logic [`PAT_ADDR_W-1:0]    host_pat_addr;
  logic [`ICON_ADDR_W-1:0]   host_icon_addr;
  logic [`PAT_ADDR_W-1:0]    fetch_addr;
  logic                      use_user;
  logic                      cursor_here;
  logic [`DOTS_W-1:0]        next_row_dots;
  logic                      pat_wr_en;
  logic                      icon_wr_en;
  logic [7:0]                pat_rd_byte;
  logic [7:0]                icon_rd_byte;
  logic [7:0]                next_rdata;
  logic [2:0]                code_glyph;
  logic                      code_in_low_block;
  logic                      glyph_in_range;
  logic [`DOTS_W-1:0]        stored_dots;
  logic                      last_row;
  icon_map_if                icon_bus ();

  // Reset release through two flops
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Strap pin synchroniser
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= ROM_OPTION_STRAPS_I;
      strap_sync <= strap_meta;
    end
  end

  // A live order change reaches the segments three clocks later
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      order_meta <= 1'b0;
      order_sync <= 1'b0;
    end else begin
      order_meta <= SEGMENT_ORDER_SELECT_I;
      order_sync <= order_meta;
    end
  end

  // Straps trade fixed ROM codes for user patterns; straps are static pins
  // Codes whose bits 2..0 are at or above the count show the fixed ROM row instead
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      user_pats <= `USER_PATS_FULL;
    end else begin
      unique case (strap_sync)
        `STRAP_248: user_pats <= `USER_PATS_FULL;
        `STRAP_250: user_pats <= `USER_PATS_250;
        `STRAP_256: user_pats <= `USER_PATS_256;
        default:    user_pats <= `USER_PATS_FULL;
      endcase
    end
  end

  // Host side addresses taken from the address counter
  assign host_pat_addr  = ADDRESS_COUNTER_I[`PAT_ADDR_W-1:0];
  assign host_icon_addr = ADDRESS_COUNTER_I[`ICON_ADDR_W-1:0];

  // Write strobes decoded once so both RAMs see the same select
  assign pat_wr_en  = RAM_WR_I && (RAM_SEL_I == user_pattern_ram_icon_pkg::SEL_USER_PATTERN);
  assign icon_wr_en = RAM_WR_I && (RAM_SEL_I == user_pattern_ram_icon_pkg::SEL_ICON);

  // RAM writes; all 64 pattern bytes keep all eight bits for readback
  // No reset here, so a glyph shows unknown dots until the host loads it
  always_ff @(posedge CORE_CLK_I) begin
    if (pat_wr_en) begin
      pattern_ram[host_pat_addr] <= WDATA_I;
    end
  end

  // Only five bits per icon location exist, 80 dots in all
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `ICON_DEPTH; i++) begin
        icon_ram[i] <= '0;
      end
    end else if (icon_wr_en) begin
      icon_ram[host_icon_addr] <= WDATA_I[`ICON_BITS-1:0];
    end
  end

  // Read data select; icon D7..D5 do not exist and read as zero
  assign pat_rd_byte  = pattern_ram[host_pat_addr];
  assign icon_rd_byte = {3'h0, icon_ram[host_icon_addr]};
  assign next_rdata   = (RAM_SEL_I == user_pattern_ram_icon_pkg::SEL_ICON) ? icon_rd_byte : pat_rd_byte;

  // Readback one cycle after the request
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_VALID_O <= 1'b0;
    end else begin
      RDATA_VALID_O <= RAM_RD_I;
    end
  end

  // Read data stands until the next read
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_O <= 8'h00;
    end else if (RAM_RD_I) begin
      RDATA_O <= next_rdata;
    end
  end

  // Glyph row fetch
  // Code bit 3 is left out of the match, so 00H and 08H alias
  assign code_glyph        = CHAR_CODE_I[2:0];
  assign code_in_low_block = (CHAR_CODE_I[7:4] == 4'h0);
  // Straps may leave fewer than eight user glyphs; the others fall back to ROM
  assign glyph_in_range    = ({1'b0, code_glyph} < user_pats);
  assign use_user          = code_in_low_block && glyph_in_range;
  assign fetch_addr        = {code_glyph, ROW_I};
  assign stored_dots       = pattern_ram[fetch_addr][`DOTS_W-1:0];
  assign last_row          = (ROW_I == `LAST_ROW);
  assign cursor_here       = CURSOR_ON_I && (TEXT_ADDR_I == ADDRESS_COUNTER_I);

  always_comb begin
    // Stored 1 lights a dot, bit 4 is leftmost; upper bits ignored
    next_row_dots = use_user ? stored_dots : ROM_ROW_I;
    // Stored eighth-row ones stay lit even without the cursor
    if (last_row && cursor_here) begin
      next_row_dots = next_row_dots | `CURSOR_ROW_DOTS;
    end
  end

  // Row valid is the fetch strobe delayed by one cycle, high for as long as FETCH_I was
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ROW_VALID_O <= 1'b0;
    end else begin
      ROW_VALID_O <= FETCH_I;
    end
  end

  // Dots and glyph source stand until the next fetch
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ROW_DOTS_O   <= '0;
      USER_GLYPH_O <= 1'b0;
    end else if (FETCH_I) begin
      ROW_DOTS_O   <= next_row_dots;
      USER_GLYPH_O <= use_user;
    end
  end

  // Icon segment mapping
  // Location n fills icon_words[5n+4:5n], D4 in the top bit
  generate
    for (genvar n = 0; n < `ICON_DEPTH; n++) begin : g_words
      assign icon_bus.icon_words[n*`ICON_BITS +: `ICON_BITS] = icon_ram[n];
    end
  endgenerate
  assign icon_bus.segment_order_select = order_sync;

  icon_segment_map u_icon_map (
    .bus (icon_bus.mapper)
  );

  // Registered so the segment pins never show the mapper settling
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ICON_SEG_O <= '0;
    end else begin
      ICON_SEG_O <= icon_bus.segments;
    end
  end

endmodule

// ---- common/user_pattern_ram_icon_consts.svh ----
// Constants for the user pattern and icon mapping block
// What this block does
// - Character code bits 0-2 become user pattern RAM address bits 3-5.
// - Pattern RAM address bits 0-2 select the glyph row.
// - Eighth displayed row is stored row ORed with the cursor.
// - Row dots come from data bits 0-4, bit 4 leftmost.
// - User pattern used only when code bits 4-7 are all zero.
// - Code bit 3 is ignored when picking a user pattern.
// - Data bit 1 lights a dot, bit 0 leaves it dark.
// - Order select 1: location n bits D4..D0 drive segments 5n+1..5n+5.
// - Order select 0: mapping reversed, location 0 D4 drives segment 80.
// - ROM option straps choose the usable pattern RAM size.
// - Exactly 80 writable icon dots held in the icon RAM.
// - Cursor appears at the text address held in the address counter.
// - Icon address comes from the address counter before data writes.
`ifndef USER_PATTERN_RAM_ICON_CONSTS_SVH
`define USER_PATTERN_RAM_ICON_CONSTS_SVH
`define PAT_ADDR_W      6
`define PAT_DEPTH       64
`define ICON_ADDR_W     4
`define ICON_DEPTH      16
`define ICON_BITS       5
`define ICON_SEGS       80
`define DOTS_W          5
`define TEXT_ADDR_W     7
`define LAST_ROW        3'h7
`define CURSOR_ROW_DOTS 5'h1F
`define STRAP_W         2
`define STRAP_248       2'h2
`define STRAP_250       2'h1
`define STRAP_256       2'h3
`define USER_PATS_FULL  4'h8
`define USER_PATS_250   4'h6
`define USER_PATS_256   4'h0
`endif

// ---- common/user_pattern_ram_icon_pkg.sv ----
// Types shared by the pattern and icon mapping modules
package user_pattern_ram_icon_pkg;
  typedef enum logic {
    SEL_USER_PATTERN,
    SEL_ICON
  } ram_sel_t;
  typedef logic [79:0] seg_vec_t;
endpackage

// ---- common/icon_map_if.sv ----
// Carrier between icon RAM storage and the segment mapper
`timescale 1ns/1ns
interface icon_map_if;
  logic [79:0] icon_words;
  logic        segment_order_select;
  logic [79:0] segments;
  modport store (output icon_words, output segment_order_select, input segments);
  modport mapper (input icon_words, input segment_order_select, output segments);
endinterface

// ---- verilog/icon_segment_map.sv ----
// Icon RAM words to segment vector, both segment orders
`timescale 1ns/1ns
module icon_segment_map (
  icon_map_if.mapper bus
);
  // Location n occupies icon_words[5n+4:5n] with D4 at the top.
  // segments[k] is segment k+1.
  genvar n, b;
  generate
    for (n = 0; n < 16; n++) begin : g_loc
      for (b = 0; b < 5; b++) begin : g_bit
        // Forward order: D4 is the lowest segment of the group
        // Reverse order: location 0 D4 is segment 80
        assign bus.segments[n*5 + 4 - b] = bus.segment_order_select ?
          bus.icon_words[n*5 + b] :
          bus.icon_words[(15-n)*5 + 4 - b];
      end
    end
  endgenerate
endmodule

// ---- sim/user_pattern_ram_icon_pattern_map_chk.sv ----
// Port assertions for the pattern and icon mapping block
`timescale 1ns/1ns
`include "user_pattern_ram_icon_consts.svh"
module user_pattern_ram_icon_pattern_map_chk (
  input wire logic CORE_CLK_I, ARST_N_I, SEGMENT_ORDER_SELECT_I, RAM_WR_I, RAM_RD_I,
  input wire logic FETCH_I, CURSOR_ON_I, RDATA_VALID_O, ROW_VALID_O, USER_GLYPH_O,
  input wire user_pattern_ram_icon_pkg::ram_sel_t RAM_SEL_I,
  input wire logic [`TEXT_ADDR_W-1:0] ADDRESS_COUNTER_I, TEXT_ADDR_I,
  input wire logic [7:0] WDATA_I, CHAR_CODE_I,
  input wire logic [2:0] ROW_I,
  input wire logic [`DOTS_W-1:0] ROM_ROW_I, ROW_DOTS_O,
  input wire user_pattern_ram_icon_pkg::seg_vec_t ICON_SEG_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  function automatic logic [4:0] rev5(input logic [4:0] v);
    rev5 = {v[0], v[1], v[2], v[3], v[4]};
  endfunction
  // Order pin is synchronised, so only writes long after a pin change are judged
  sequence icon_wr;
    $stable(SEGMENT_ORDER_SELECT_I)[*5] ##0 RAM_WR_I && RAM_SEL_I == user_pattern_ram_icon_pkg::SEL_ICON;
  endsequence
  sequence cur_hit;
    FETCH_I && ROW_I == 3'h7 && CURSOR_ON_I && TEXT_ADDR_I == ADDRESS_COUNTER_I;
  endsequence
  rd_valid_a: assert property (RAM_RD_I |=> RDATA_VALID_O) else $error("no read valid");
  row_valid_a: assert property (FETCH_I |=> ROW_VALID_O) else $error("no row valid");
  rom_select_a: assert property (FETCH_I && CHAR_CODE_I[7:4] != 4'h0 |=> !USER_GLYPH_O)
    else $error("user glyph for high code");
  rom_dots_a: assert property (FETCH_I && CHAR_CODE_I[7:4] != 4'h0 && ROW_I != 3'h7
    |=> ROW_DOTS_O == $past(ROM_ROW_I)) else $error("rom dots");
  cursor_or_a: assert property (cur_hit |=> ROW_DOTS_O == 5'h1F) else $error("cursor");
  dots_hold_a: assert property (!FETCH_I |=> $stable(ROW_DOTS_O)) else $error("dots moved");
  icon_fwd_a: assert property (icon_wr ##0 SEGMENT_ORDER_SELECT_I |-> ##2
    ICON_SEG_O[5*$past(ADDRESS_COUNTER_I[3:0], 2) +: 5] == rev5($past(WDATA_I[4:0], 2)))
    else $error("icon forward");
  icon_rev_a: assert property (icon_wr ##0 !SEGMENT_ORDER_SELECT_I |-> ##2
    ICON_SEG_O[75-5*$past(ADDRESS_COUNTER_I[3:0], 2) +: 5] == $past(WDATA_I[4:0], 2))
    else $error("icon reverse");
endmodule
bind user_pattern_ram_icon_pattern_map user_pattern_ram_icon_pattern_map_chk chk_u (.CORE_CLK_I, .ARST_N_I,
  .SEGMENT_ORDER_SELECT_I, .RAM_WR_I, .RAM_RD_I, .FETCH_I, .CURSOR_ON_I, .RDATA_VALID_O,
  .ROW_VALID_O, .USER_GLYPH_O, .RAM_SEL_I, .ADDRESS_COUNTER_I, .TEXT_ADDR_I, .WDATA_I,
  .CHAR_CODE_I, .ROW_I, .ROM_ROW_I, .ROW_DOTS_O, .ICON_SEG_O);

// ---- sim/host_model.sv ----
// Host side model that writes and reads the pattern and icon RAMs
`timescale 1ns/1ns
`include "user_pattern_ram_icon_consts.svh"
module host_model (
  // Clock and read answer
  input  wire logic                clk_i,
  input  wire logic [7:0]          rdata_i,
  input  wire logic                rvalid_i,
  // RAM access
  output logic                     wr_o,
  output logic                     rd_o,
  output user_pattern_ram_icon_pkg::ram_sel_t sel_o,
  output logic [`TEXT_ADDR_W-1:0]  ac_o,
  output logic [7:0]               wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    sel_o = user_pattern_ram_icon_pkg::SEL_USER_PATTERN;
    ac_o = '0;
    wdata_o = 8'h00;
  end
  task automatic access(input user_pattern_ram_icon_pkg::ram_sel_t s, input logic [5:0] a,
                        input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    sel_o = s;
    ac_o = {1'b0, a};
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released data is inverted so a stale byte cannot pass as fresh
    wdata_o = ~d;
    q = rvalid_i ? rdata_i : 8'hXX;
  endtask
endmodule

// ---- sim/tb_user_pattern_ram_icon_pattern_map.sv ----
// Self-checking bench for the pattern and icon mapping block
`timescale 1ns/1ns
`include "user_pattern_ram_icon_consts.svh"
module tb_user_pattern_ram_icon_pattern_map;
  logic clk = 1'b0, arst_n = 1'b0, order = 1'b1, freq = 1'b0, cur = 1'b0;
  logic wr, rd, rvld, row_vld, user;
  logic [1:0] straps = 2'h0;
  logic [7:0] code = 8'h00, wdata, rdata, q;
  logic [2:0] row = 3'h0;
  logic [`TEXT_ADDR_W-1:0] taddr = '0, ac;
  logic [4:0] rom = 5'h00, dots;
  user_pattern_ram_icon_pkg::ram_sel_t sel;
  user_pattern_ram_icon_pkg::seg_vec_t seg, fw, rv;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  localparam user_pattern_ram_icon_pkg::ram_sel_t PAT = user_pattern_ram_icon_pkg::SEL_USER_PATTERN;
  localparam user_pattern_ram_icon_pkg::ram_sel_t ICO = user_pattern_ram_icon_pkg::SEL_ICON;
  user_pattern_ram_icon_pattern_map dut_u (.CORE_CLK_I(clk), .ARST_N_I(arst_n),
    .ROM_OPTION_STRAPS_I(straps), .SEGMENT_ORDER_SELECT_I(order), .RAM_WR_I(wr),
    .RAM_RD_I(rd), .RAM_SEL_I(sel), .ADDRESS_COUNTER_I(ac), .WDATA_I(wdata),
    .RDATA_O(rdata), .RDATA_VALID_O(rvld), .FETCH_I(freq), .CHAR_CODE_I(code), .ROW_I(row),
    .TEXT_ADDR_I(taddr), .CURSOR_ON_I(cur), .ROM_ROW_I(rom), .ROW_DOTS_O(dots),
    .ROW_VALID_O(row_vld), .USER_GLYPH_O(user), .ICON_SEG_O(seg));
  host_model host_u (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvld), .wr_o(wr), .rd_o(rd),
    .sel_o(sel), .ac_o(ac), .wdata_o(wdata));
  always #5 clk = ~clk;
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // ROM dots are made from code and row so each fetch has its own ROM value
  task automatic fetch(input logic [7:0] c, input logic [2:0] r, input logic cu,
                       input logic [6:0] ta, input logic [4:0] exp, input logic u);
    @(posedge clk);
    #1;
    {freq, code, row, cur, taddr, rom} = {1'b1, c, r, cu, ta, c[4:0] ^ {2'h0, r}};
    @(posedge clk);
    #1;
    freq = 1'b0;
    chk(row_vld, 1'b1);
    chk({dots, user}, {exp, u});
  endtask
  task automatic t_ram;
    host_u.access(PAT, 6'h3F, 1'b1, 8'hA5, q);
    host_u.access(PAT, 6'h3F, 1'b0, 8'h00, q);
    chk(q, 8'hA5);
    host_u.access(ICO, 6'h03, 1'b1, 8'hFF, q);
    host_u.access(ICO, 6'h03, 1'b0, 8'h00, q);
    chk(q, 8'h1F);
  endtask
  task automatic t_user;
    for (int r = 0; r < 7; r++)
      host_u.access(PAT, {3'h5, 3'(r)}, 1'b1, 8'hE0 | 8'(r * 3), q);
    host_u.access(PAT, 6'h2F, 1'b1, 8'h00, q);
    host_u.access(PAT, 6'h37, 1'b1, 8'h04, q);
    for (int r = 0; r < 7; r++) begin
      fetch(8'h05, 3'(r), 1'b1, ac, 5'(r * 3), 1'b1);
      fetch(8'h0D, 3'(r), 1'b0, ac, 5'(r * 3), 1'b1);
    end
    fetch(8'h05, 3'h7, 1'b1, ac, 5'h1F, 1'b1);
    fetch(8'h05, 3'h7, 1'b1, ac ^ 7'h01, 5'h00, 1'b1);
    fetch(8'h0E, 3'h7, 1'b0, ac, 5'h04, 1'b1);
  endtask
  task automatic t_rom;
    fetch(8'h10, 3'h3, 1'b0, ac, 5'h13, 1'b0);
    fetch(8'hF5, 3'h7, 1'b1, ac, 5'h1F, 1'b0);
    straps = 2'h1;
    repeat (6) @(posedge clk);
    fetch(8'h05, 3'h1, 1'b0, ac, 5'h03, 1'b1);
    fetch(8'h06, 3'h1, 1'b0, ac, 5'h07, 1'b0);
    straps = 2'h3;
    repeat (6) @(posedge clk);
    fetch(8'h02, 3'h1, 1'b0, ac, 5'h03, 1'b0);
    fetch(8'h05, 3'h1, 1'b0, ac, 5'h04, 1'b0);
  endtask
  task automatic t_icon;
    fw = '0;
    rv = '0;
    for (int n = 0; n < 16; n++) begin
      host_u.access(ICO, 6'(n), 1'b1, 8'(n + 1), q);
      for (int b = 0; b < 5; b++) begin
        fw[5 * n + 4 - b] = 1'((n + 1) >> b);
        rv[75 - 5 * n + b] = 1'((n + 1) >> b);
      end
    end
    repeat (3) @(posedge clk);
    #1;
    chk(seg, fw);
    order = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(seg, rv);
    host_u.access(ICO, 6'h00, 1'b1, 8'h10, q);
    rv[79:75] = 5'h10;
    repeat (2) @(posedge clk);
    #1;
    chk(seg, rv);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(seg, '0);
    t_ram();
    t_user();
    t_icon();
    t_rom();
    end_of_test();
  end
endmodule
